// [hdl/dvs_defs.svh]
// Constants for the regulator control register bank
`ifndef DVS_DEFS_SVH
`define DVS_DEFS_SVH
`define DVS_TARGET_ADDR     7'h5b
`define DVS_OFF_ENSTAT      3'h1
`define DVS_OFF_SETA        3'h2
`define DVS_OFF_SETB        3'h3
`define DVS_RST_ENSTAT      2'h1
`define DVS_RST_SETA        8'h1e
`define DVS_RST_SETB        8'h0a
`define DVS_CODE_MAX        8'haa
`define DVS_BIT_ENABLE      0
`define DVS_BIT_LONG_SS     1
`define DVS_BIT_POWER_GOOD  4
`define DVS_BIT_UNDERVOLTAGE_LOCKOUT_FLAG        5
`define DVS_BIT_THERMAL     6
`endif

// [hdl/dvs_pkg.sv]
// Types shared by the regulator control register bank
package dvs_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV_ADDR,
    ST_REG_ADDR,
    ST_WR_DATA,
    ST_RD_DATA,
    ST_ACK,
    ST_RD_ACK,
    ST_IGNORE
  } dvs_i2c_state_t;
endpackage

// [hdl/dvs_sync.sv]
// Two flip-flop synchroniser for pins from outside the clock domain
`timescale 1ns/10ps
`default_nettype none
module dvs_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  if (WIDTH < 1) begin : g_width_check
    $error("synchroniser width must be at least one");
  end

  // Reset to the idle level of each pin, so no false edge follows reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= RST_VAL;
      sync_reg <= RST_VAL;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  assign o_sync = sync_reg;
endmodule
`default_nettype wire

// [hdl/dvs_regs.sv]
// I2C target and register bank of the dynamic voltage scaling regulator
// Operation
// - Register 01h holds enable and long soft-start; reads return fault and good flags.
// - Two writable 8-bit set-point registers sit at 02h and 03h.
// - Output is 0.7 V plus 10 mV per code, 171 levels (codes 0 to 170).
// - Codes written above 170 act as 170.
// - Select pin low uses set-point A, high uses set-point B.
// - Writing the selected set point while enabled starts a transition at once.
// - Bit 6 shows thermal shutdown, set by hardware.
// - Bit 5 shows undervoltage lockout while active, clears when input recovers.
// - Bit 4 shows power good and mirrors the power-good pin.
// - Bit 1 set selects the longer soft-start.
// - Bit 0 set enables the output, clear disables it.
// - Target address is 1011011 followed by read/write bit, 0 write.
// - Register address byte is eight bits, only low three decoded.
// - Registers held at zero while chip enable low, load defaults when high.
`timescale 1ns/10ps
`default_nettype none
`include "dvs_defs.svh"
module dvs_regs (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_scl,
  input  wire logic       i_sda,
  input  wire logic       i_chip_en,
  input  wire logic       i_vsel,
  input  wire logic       i_thermal_shutdown,
  input  wire logic       i_undervoltage_lockout,
  input  wire logic       i_power_good,
  output logic            o_sda_out,
  output logic            o_sda_oe,
  output logic            o_enable,
  output logic            o_long_soft_start,
  output logic [7:0]      o_setpoint_code,
  output logic            o_transition
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [5:0] pins_sync;
  dvs_sync #(.WIDTH(6), .RST_VAL(6'h30)) u_sync (  // Bus pins idle high
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_async ({i_scl, i_sda, i_chip_en, i_vsel, i_thermal_shutdown, i_undervoltage_lockout}),
    .o_sync  (pins_sync)
  );
  logic scl_s, sda_s, ce_s, vsel_s, tsd_s, undervoltage_lockout_flag_s, pg_s_reg;
  assign {scl_s, sda_s, ce_s, vsel_s, tsd_s, undervoltage_lockout_flag_s} = pins_sync;

  function automatic logic [7:0] clamp_code(input logic [7:0] code);
    clamp_code = (code > `DVS_CODE_MAX) ? `DVS_CODE_MAX : code;
  endfunction

  // ----------------------------------------------------------------
  // Bus edge and framing detection
  // ----------------------------------------------------------------
  logic scl_d_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_c, stop_c;
  // Power good comes from a same-domain monitor, so one stage is enough
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      pg_s_reg  <= 1'b0;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
      pg_s_reg  <= i_power_good;
    end
  end
  assign scl_rise = scl_s & ~scl_d_reg;
  assign scl_fall = ~scl_s & scl_d_reg;
  assign start_c  = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  assign stop_c   = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

  // ----------------------------------------------------------------
  // Target state machine
  // ----------------------------------------------------------------
  dvs_pkg::dvs_i2c_state_t state_reg, state_next, ret_reg, ret_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [2:0] ptr_reg, ptr_next;
  logic       sda_oe_reg, sda_oe_next, sda_out_reg, sda_out_next;
  logic       wr_stb;
  logic [7:0] rd_data;
  logic       en_reg, en_next, ssl_reg, ssl_next;
  logic [7:0] seta_reg, seta_next, setb_reg, setb_next;
  logic [7:0] code_reg, code_next;
  logic       trans_reg, trans_next;

  always_comb begin
    unique case (ptr_reg)
      `DVS_OFF_ENSTAT: begin
        rd_data = 8'h00;
        rd_data[`DVS_BIT_THERMAL]    = tsd_s;
        rd_data[`DVS_BIT_UNDERVOLTAGE_LOCKOUT_FLAG]       = undervoltage_lockout_flag_s;
        rd_data[`DVS_BIT_POWER_GOOD] = pg_s_reg;
        rd_data[`DVS_BIT_LONG_SS]    = ssl_reg;
        rd_data[`DVS_BIT_ENABLE]     = en_reg;
      end
      `DVS_OFF_SETA: rd_data = seta_reg;
      `DVS_OFF_SETB: rd_data = setb_reg;
      default: rd_data = 8'h00;
    endcase
  end

  always_comb begin
    state_next   = state_reg;
    ret_next     = ret_reg;
    shift_next   = shift_reg;
    cnt_next     = cnt_reg;
    ptr_next     = ptr_reg;
    sda_oe_next  = sda_oe_reg;
    sda_out_next = 1'b0;
    wr_stb       = 1'b0;
    if (start_c) begin
      state_next  = dvs_pkg::ST_DEV_ADDR;
      cnt_next    = 4'h0;
      sda_oe_next = 1'b0;
    end else if (stop_c || !ce_s) begin
      state_next  = dvs_pkg::ST_IDLE;
      sda_oe_next = 1'b0;
    end else begin
      case (state_reg)
        dvs_pkg::ST_DEV_ADDR, dvs_pkg::ST_REG_ADDR, dvs_pkg::ST_WR_DATA: begin
          if (scl_rise) begin
            shift_next = {shift_reg[6:0], sda_s};
            cnt_next   = cnt_reg + 4'h1;
          end
          if (scl_fall && cnt_reg == 4'h8) begin
            cnt_next = 4'h0;
            if (state_reg == dvs_pkg::ST_DEV_ADDR) begin
              if (shift_reg[7:1] == `DVS_TARGET_ADDR) begin
                sda_oe_next = 1'b1;
                state_next  = dvs_pkg::ST_ACK;
                ret_next    = shift_reg[0] ? dvs_pkg::ST_RD_DATA : dvs_pkg::ST_REG_ADDR;
                shift_next  = rd_data; // Writes shift over it unused
              end else begin
                state_next = dvs_pkg::ST_IGNORE;
              end
            end else begin
              sda_oe_next = 1'b1;
              state_next  = dvs_pkg::ST_ACK;
              ret_next    = dvs_pkg::ST_WR_DATA;
              if (state_reg == dvs_pkg::ST_REG_ADDR) begin
                ptr_next = shift_reg[2:0];
              end else begin
                wr_stb   = 1'b1;
                ptr_next = ptr_reg + 3'h1;
              end
            end
          end
        end
        dvs_pkg::ST_ACK: begin
          if (scl_fall) begin
            state_next  = ret_reg;
            sda_oe_next = 1'b0;
            if (ret_reg == dvs_pkg::ST_RD_DATA) begin
              sda_oe_next = ~shift_reg[7];
              shift_next  = {shift_reg[6:0], 1'b0};
              cnt_next    = 4'h1;
            end
          end
        end
        dvs_pkg::ST_RD_DATA: begin
          if (scl_fall) begin
            sda_oe_next = ~shift_reg[7];
            shift_next  = {shift_reg[6:0], 1'b0};
            cnt_next    = cnt_reg + 4'h1;
            if (cnt_reg == 4'h8) begin
              sda_oe_next = 1'b0;
              state_next  = dvs_pkg::ST_RD_ACK;
              ptr_next    = ptr_reg + 3'h1;
            end
          end
        end
        dvs_pkg::ST_RD_ACK: begin
          // Master ack asks for the next byte, nack ends the read
          if (scl_rise) begin
            state_next = sda_s ? dvs_pkg::ST_IGNORE : dvs_pkg::ST_ACK;
            ret_next   = dvs_pkg::ST_RD_DATA;
            shift_next = rd_data;
          end
        end
        default: state_next = state_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Register bank; chip enable low holds all registers at zero
  // ----------------------------------------------------------------
  logic ce_d_reg, ce_d_next;
  always_comb begin
    en_next    = en_reg;
    ssl_next   = ssl_reg;
    seta_next  = seta_reg;
    setb_next  = setb_reg;
    ce_d_next  = ce_s;
    trans_next = 1'b0;
    if (!ce_s) begin
      {en_next, ssl_next, seta_next, setb_next} = 18'h0_0000;
    end else if (!ce_d_reg) begin
      {ssl_next, en_next} = `DVS_RST_ENSTAT;
      seta_next = `DVS_RST_SETA;
      setb_next = `DVS_RST_SETB;
    end else if (wr_stb) begin
      case (ptr_reg)
        `DVS_OFF_ENSTAT: begin
          en_next  = shift_reg[`DVS_BIT_ENABLE];
          ssl_next = shift_reg[`DVS_BIT_LONG_SS];
        end
        `DVS_OFF_SETA: seta_next = shift_reg;
        `DVS_OFF_SETB: setb_next = shift_reg;
        default: ;
      endcase
      trans_next = en_reg && ((ptr_reg == `DVS_OFF_SETA && !vsel_s)
                              || (ptr_reg == `DVS_OFF_SETB && vsel_s));
    end
    code_next = clamp_code(vsel_s ? setb_next : seta_next);
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg   <= dvs_pkg::ST_IDLE;
      ret_reg     <= dvs_pkg::ST_IDLE;
      shift_reg   <= 8'h00;
      cnt_reg     <= 4'h0;
      ptr_reg     <= 3'h0;
      sda_oe_reg  <= 1'b0;
      sda_out_reg <= 1'b0;
      en_reg      <= 1'b0;
      ssl_reg     <= 1'b0;
      seta_reg    <= 8'h00;
      setb_reg    <= 8'h00;
      code_reg    <= 8'h00;
      trans_reg   <= 1'b0;
      ce_d_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      ret_reg     <= ret_next;
      shift_reg   <= shift_next;
      cnt_reg     <= cnt_next;
      ptr_reg     <= ptr_next;
      sda_oe_reg  <= sda_oe_next;
      sda_out_reg <= sda_out_next;
      en_reg      <= en_next;
      ssl_reg     <= ssl_next;
      seta_reg    <= seta_next;
      setb_reg    <= setb_next;
      code_reg    <= code_next;
      trans_reg   <= trans_next;
      ce_d_reg    <= ce_d_next;
    end
  end

  assign o_sda_out         = sda_out_reg;
  assign o_sda_oe          = sda_oe_reg;
  assign o_enable          = en_reg;
  assign o_long_soft_start = ssl_reg;
  assign o_setpoint_code   = code_reg;
  assign o_transition      = trans_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  code_clamp_a: assert property (o_setpoint_code <= `DVS_CODE_MAX)
    else $error("setpoint code above limit");
  code_select_a: assert property (##1 o_setpoint_code == clamp_code($past(vsel_s) ? setb_reg : seta_reg))
    else $error("setpoint code not from selected register");
  trans_cause_a: assert property (o_transition |-> $past(en_reg) && $past(wr_stb))
    else $error("transition without enabled write");
  ce_zero_a: assert property (!ce_s |=> !o_enable && seta_reg == 8'h00 && setb_reg == 8'h00)
    else $error("registers not cleared by chip enable");
  ce_default_a: assert property ($rose(ce_s) |=> seta_reg == `DVS_RST_SETA && setb_reg == `DVS_RST_SETB && o_enable)
    else $error("defaults not loaded");
  unmapped_read_a: assert property (ptr_reg > `DVS_OFF_SETB || ptr_reg == 3'h0 |-> rd_data == 8'h00)
    else $error("unmapped read not zero");
  reserved_zero_a: assert property (ptr_reg == `DVS_OFF_ENSTAT |-> rd_data[7] == 1'b0 && rd_data[3:2] == 2'b00)
    else $error("reserved bits not zero");
  flag_mirror_a: assert property (ptr_reg == `DVS_OFF_ENSTAT |-> rd_data[`DVS_BIT_POWER_GOOD] == pg_s_reg
                                  && rd_data[`DVS_BIT_THERMAL] == tsd_s && rd_data[`DVS_BIT_UNDERVOLTAGE_LOCKOUT_FLAG] == undervoltage_lockout_flag_s)
    else $error("status flags do not follow inputs");
  enable_write_a: assert property (wr_stb && ce_s && ce_d_reg && ptr_reg == `DVS_OFF_ENSTAT
                                   |=> o_enable == $past(shift_reg[0]) && o_long_soft_start == $past(shift_reg[1]))
    else $error("enable write not taken");
  addr_match_a: assert property (state_reg == dvs_pkg::ST_DEV_ADDR && state_next == dvs_pkg::ST_ACK
                                 |-> shift_reg[7:1] == `DVS_TARGET_ADDR)
    else $error("ack to foreign address");
endmodule
`default_nettype wire

// [dv/dvs_i2c_master.sv]
// Bus controller model driving the serial port of the register bank
`timescale 1ns/10ps
`default_nettype none
module dvs_i2c_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  // ----------------------------------------
  // Bus timing
  // ----------------------------------------
  // Eight system clocks a quarter gives a 160 ns bus clock
  localparam int QTR = 8;
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end
  task automatic wait_q();
    repeat (QTR) @(posedge i_clk);
    #1;
  endtask
  // SDA never moves in the quarter of an SCL edge: no false start or stop
  task automatic start();
    wait_q();
    o_sda_pull = 1'b0;
    wait_q();
    o_scl = 1'b1;
    wait_q();
    o_sda_pull = 1'b1;
    wait_q();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    wait_q();
    o_sda_pull = 1'b1;
    wait_q();
    o_scl = 1'b1;
    wait_q();
    o_sda_pull = 1'b0;
    wait_q();
  endtask
  // ----------------------------------------
  // Byte and transfer sequences
  // ----------------------------------------
  // Nine bits, MSB first; a released line reads high via the pull-up
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic nak);
    logic [8:0] sh;
    logic [8:0] rv;
    sh = {tx, last};
    for (int i = 8; i >= 0; i--) begin
      wait_q();
      o_sda_pull = ~sh[i];
      wait_q();
      o_scl = 1'b1;
      wait_q();
      rv[i] = i_sda;
      wait_q();
      o_scl = 1'b0;
    end
    rx = rv[8:1];
    nak = rv[0];
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d, output logic [2:0] nak);
    logic [7:0] rx;
    start();
    xfer(dev, 1'b1, rx, nak[2]);
    xfer(a, 1'b1, rx, nak[1]);
    xfer(d, 1'b1, rx, nak[0]);
    stop();
  endtask
  // Pointer write, repeated start, one byte closed by no-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [2:0] nak);
    logic [7:0] rx;
    start();
    xfer(8'hb6, 1'b1, rx, nak[2]);
    xfer(a, 1'b1, rx, nak[1]);
    start();
    xfer(8'hb7, 1'b1, rx, nak[0]);
    xfer(8'hff, 1'b1, d, rx[0]);
    stop();
  endtask
  // Two-byte read; the master acknowledge asks for the next register
  task automatic rd2(input logic [7:0] a, output logic [15:0] d, output logic [2:0] nak);
    logic [7:0] rx;
    logic [7:0] hi;
    logic [7:0] lo;
    start();
    xfer(8'hb6, 1'b1, rx, nak[2]);
    xfer(a, 1'b1, rx, nak[1]);
    start();
    xfer(8'hb7, 1'b1, rx, nak[0]);
    xfer(8'hff, 1'b0, hi, rx[0]);
    xfer(8'hff, 1'b1, lo, rx[0]);
    stop();
    d = {hi, lo};
  endtask
endmodule
`default_nettype wire

// [dv/dvs_regs_tb.sv]
// Self-checking bench for the regulator control register bank
`timescale 1ns/10ps
`default_nettype none
module dvs_regs_tb;
  logic       clk;
  logic       rst_n;
  logic       chip_en;
  logic       vsel;
  logic       therm;
  logic       undervoltage_lockout_flag;
  logic       power_good_flag;
  logic       scl;
  logic       pull;
  logic       sda_line;
  logic       sda_out;
  logic       sda_oe;
  logic       en;
  logic       lss;
  logic [7:0] setpt;
  logic       trans;
  logic [7:0] d;
  logic [15:0] d2;
  logic [2:0] nak;
  logic [7:0] codes [4] = '{8'ha9, 8'haa, 8'hab, 8'hff};
  int         fails = 0;
  int         compares = 0;
  int         trans_cnt = 0;
  int         t0 = 0;
  // Open-drain line with pull-up
  assign sda_line = ~pull & (~sda_oe | sda_out);
  always #2.5 clk = ~clk;
  always @(posedge clk) if (trans === 1'b1) trans_cnt++;
  dvs_regs DUT (.i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_line), .i_chip_en(chip_en),
    .i_vsel(vsel), .i_thermal_shutdown(therm), .i_undervoltage_lockout(undervoltage_lockout_flag), .i_power_good(power_good_flag),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_enable(en), .o_long_soft_start(lss),
    .o_setpoint_code(setpt), .o_transition(trans));
  dvs_i2c_master m (.i_clk(clk), .i_sda(sda_line), .o_scl(scl), .o_sda_pull(pull));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic report_and_stop();
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    m.wr(8'hb6, a, v, nak);
    check({5'h00, nak}, 8'h00);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    m.rd(a, d, nak);
    check({5'h00, nak}, 8'h00);
    check(d, exp);
  endtask
  task automatic trans_chk(input int n);
    check(8'(trans_cnt - t0), 8'(n));
    t0 = trans_cnt;
  endtask
  // Bus transfers are slow; this bound is far above the whole sequence
  initial begin
    repeat (90000) @(posedge clk);
    fails++;
    report_and_stop();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    chip_en = 1'b0;
    vsel = 1'b0;
    {therm, undervoltage_lockout_flag, power_good_flag} = 3'b000;
    tick(4);
    rst_n = 1'b1;
    tick(4);
    chip_en = 1'b1;
    tick(8);
    check(setpt, 8'h1e);
    check({7'h00, en}, 8'h01);
    rd_chk(8'h01, 8'h01);
    rd_chk(8'h02, 8'h1e);
    rd_chk(8'h03, 8'h0a);
    t0 = trans_cnt;
    wr_reg(8'h02, 8'h50);
    check(setpt, 8'h50);
    trans_chk(1);
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'h02, codes[i]);
      check(setpt, (codes[i] > 8'haa) ? 8'haa : codes[i]);
    end
    trans_chk(4);
    vsel = 1'b1;
    tick(8);
    check(setpt, 8'h0a);
    wr_reg(8'h02, 8'h11);
    trans_chk(0);
    wr_reg(8'h03, 8'h22);
    check(setpt, 8'h22);
    trans_chk(1);
    vsel = 1'b0;
    tick(8);
    check(setpt, 8'h11);
    wr_reg(8'h01, 8'hff);
    rd_chk(8'h01, 8'h03);
    check({6'h00, lss, en}, 8'h03);
    wr_reg(8'h01, 8'h00);
    check({6'h00, lss, en}, 8'h00);
    wr_reg(8'h02, 8'h40);
    trans_chk(0);
    wr_reg(8'h01, 8'h71);
    rd_chk(8'h01, 8'h01);
    for (int i = 0; i < 3; i++) begin
      {therm, undervoltage_lockout_flag, power_good_flag} = 3'b001 << i;
      tick(8);
      rd_chk(8'h01, 8'h01 | (8'h10 << i));
    end
    {therm, undervoltage_lockout_flag, power_good_flag} = 3'b000;
    tick(8);
    rd_chk(8'h01, 8'h01);
    wr_reg(8'h05, 8'h77);
    rd_chk(8'h05, 8'h00);
    rd_chk(8'h00, 8'h00);
    rd_chk(8'h02, 8'h40);
    wr_reg(8'h0b, 8'h5a);
    rd_chk(8'h03, 8'h5a);
    m.rd2(8'h02, d2, nak);
    check({5'h00, nak}, 8'h00);
    check(d2[15:8], 8'h40);
    check(d2[7:0], 8'h5a);
    m.wr(8'hb4, 8'h03, 8'h99, nak);
    check({5'h00, nak}, 8'h07);
    m.wr(8'h36, 8'h03, 8'h99, nak);
    check({5'h00, nak}, 8'h07);
    rd_chk(8'h03, 8'h5a);
    chip_en = 1'b0;
    tick(8);
    check(setpt, 8'h00);
    check({7'h00, en}, 8'h00);
    chip_en = 1'b1;
    tick(8);
    rd_chk(8'h03, 8'h0a);
    check(setpt, 8'h1e);
    report_and_stop();
  end
endmodule
`default_nettype wire
